// *** design/uart_line_status_params.svh ***
`ifndef UART_LINE_STATUS_PARAMS_SVH
`define UART_LINE_STATUS_PARAMS_SVH
// Overview of operation
// - data ready sets when a complete character lands in buffer or fifo
// - character mode: reading the receive buffer clears data ready
// - fifo mode: data ready sets on push, clears only when fifo empty
// - character mode: new character over unread one flags overrun, old lost
// - status read clears overrun, parity, framing and break flags
// - fifo mode: full fifo plus new character flags overrun, no push
// - parity fault sets when parity mismatches the selected odd or even sense
// - fifo mode: error bits travel with each character, shown at head only
// - framing fault sets when the first stop bit samples low
// - line break flag sets when input stays low beyond one whole frame
// - after a break, reception resumes only after half a bit of high
// - line status interrupt raised when any of bits 1 to 4 is set
// - software writes set or clear bits 0 to 6; in fifo mode bits 0, 5 and 6 follow the fifos, in character mode bit 6 follows holder and shifter next cycle
// - character mode: holding empty sets on transfer to shifter, clears on load
// - fifo mode: holding empty follows transmit fifo empty
// - fifo mode: empty indication delayed unless two characters were held
// - toggling fifo enable gives an immediate transmit empty interrupt
// - character mode: all idle when holder and shifter empty, clears on load
// - fifo mode: all idle when fifo and shifter empty, clears on write
// - bit 7 zero in character mode, fifo error summary in fifo mode
// - line control bit 3 enables parity, bit 4 picks odd or even
// - fifo control bit 0 written one enters fifo mode
// - line status interrupt only while interrupt enable bit 2 is one

// register addresses
`define ADDR_DATA      3'h0
`define ADDR_INT_EN    3'h1
`define ADDR_FIFO_CTRL 3'h2
`define ADDR_LINE_CTRL 3'h3
`define ADDR_LINE_STAT 3'h5

// line status fields
`define LS_DR   0
`define LS_OE   1
`define LS_PE   2
`define LS_FE   3
`define LS_BI   4
`define LS_TX_HOLDING_EMPTY 5
`define LS_TX_ALL_IDLE 6
`define LS_ERR7 7

// line control, fifo control, interrupt enable fields
`define LC_PAR_EN  3
`define LC_EVEN    4
`define LC_STOP2   2
`define FC_ENABLE  0
`define FC_RX_CLR  1
`define FC_TX_CLR  2
`define IE_TX_HOLDING_EMPTY    1
`define IE_RLS     2

// reset values
`define RST_LINE_CTRL 8'h03
`define RST_INT_EN    4'h0

// timing: half bit wait after break, numerator over denominator
`define HALF_BIT_NUM 1
`define HALF_BIT_DEN 2
`endif

// *** design/uart_line_status_pkg.sv ***
package uart_line_status_pkg;
	typedef enum logic [5:0] {
		RX_IDLE  = 6'h01,
		RX_START = 6'h02,
		RX_DATA  = 6'h04,
		RX_PAR   = 6'h08,
		RX_STOP  = 6'h10,
		RX_WAIT  = 6'h20
	} rx_state_type;

	function automatic logic [7:0] data_mask(input logic [1:0] wl);
		data_mask = 8'hff >> (2'h3 - wl);
	endfunction

	// odd sense: total ones odd; even sense: total ones even
	function automatic logic parity_gen(input logic [7:0] d, input logic [1:0] wl,
		input logic even);
		parity_gen = even ? ^(d & data_mask(wl)) : ~^(d & data_mask(wl));
	endfunction

	function automatic logic parity_bad(input logic [7:0] d, input logic [1:0] wl,
		input logic even, input logic pbit);
		parity_bad = pbit != parity_gen(d, wl, even);
	endfunction

	// frame length in bits less the final stop bit
	function automatic logic [3:0] frame_less_stop(input logic [7:0] lc);
		frame_less_stop = 4'h6 + {2'h0, lc[1:0]} + {3'h0, lc[3]} + {3'h0, lc[2]};
	endfunction
endpackage

// *** design/rx_link_if.sv ***
`timescale 1ns/1ps
interface rx_link_if;
	logic [1:0] word_len;
	logic       par_en;
	logic       even;
	logic       done;
	logic [7:0] data;
	logic       perr;
	logic       ferr;
	logic       brk;
	modport status (output word_len, par_en, even, input done, data, perr, ferr, brk);
	modport rx     (input word_len, par_en, even, output done, data, perr, ferr, brk);
endinterface

// *** design/uart_rx_frame.sv ***
`timescale 1ns/1ps
`include "uart_line_status_params.svh"
module uart_rx_frame #(
	parameter int CPB = 16
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic arst_n,
	// line
	input  wire logic serial_input,
	// status side
	rx_link_if.rx     lnk
);
	import uart_line_status_pkg::*;

	localparam logic [15:0] BIT_CYC  = 16'(CPB);
	localparam logic [15:0] HALF_CYC = 16'((CPB * `HALF_BIT_NUM + `HALF_BIT_DEN - 1)
		/ `HALF_BIT_DEN);

	if (CPB < 2 || CPB > 65535) begin : g_bad_cpb
		$error("cycles per bit out of range");
	end

	typedef struct packed {
		rx_state_type st;
		logic [15:0]  cnt;
		logic [2:0]   idx;
		logic [7:0]   sh;
		logic         pbit;
		logic         done;
		logic [7:0]   data;
		logic         perr;
		logic         ferr;
		logic         brk;
	} rx_regs_type;

	rx_regs_type s_ff;
	rx_regs_type nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		case (s_ff.st)
			RX_IDLE: begin
				if (!serial_input) begin
					nxt_s.st = RX_START;
					nxt_s.cnt = HALF_CYC - 16'h1;
				end
			end
			RX_START: begin
				if (s_ff.cnt != 16'h0) begin
					nxt_s.cnt = s_ff.cnt - 16'h1;
				end else if (serial_input) begin
					nxt_s.st = RX_IDLE;
				end else begin
					nxt_s.st = RX_DATA;
					nxt_s.cnt = BIT_CYC - 16'h1;
					nxt_s.idx = 3'h0;
					nxt_s.sh = 8'h00;
				end
			end
			RX_DATA: begin
				if (s_ff.cnt != 16'h0) begin
					nxt_s.cnt = s_ff.cnt - 16'h1;
				end else begin
					nxt_s.sh[s_ff.idx] = serial_input;
					nxt_s.cnt = BIT_CYC - 16'h1;
					nxt_s.idx = s_ff.idx + 3'h1;
					if (s_ff.idx == {1'b1, lnk.word_len}) begin
						nxt_s.st = lnk.par_en ? RX_PAR : RX_STOP;
					end
				end
			end
			RX_PAR: begin
				if (s_ff.cnt != 16'h0) begin
					nxt_s.cnt = s_ff.cnt - 16'h1;
				end else begin
					nxt_s.pbit = serial_input;
					nxt_s.st = RX_STOP;
					nxt_s.cnt = BIT_CYC - 16'h1;
				end
			end
			RX_STOP: begin
				if (s_ff.cnt != 16'h0) begin
					nxt_s.cnt = s_ff.cnt - 16'h1;
				end else begin
					nxt_s.done = 1'b1;
					nxt_s.data = s_ff.sh;
					nxt_s.ferr = !serial_input;
					nxt_s.perr = lnk.par_en &&
						parity_bad(s_ff.sh, lnk.word_len, lnk.even, s_ff.pbit);
					// low from start through stop: longer than a frame
					nxt_s.brk = !serial_input && s_ff.sh == 8'h00 &&
						!(lnk.par_en && s_ff.pbit);
					nxt_s.st = nxt_s.brk ? RX_WAIT : RX_IDLE;
					nxt_s.cnt = HALF_CYC - 16'h1;
				end
			end
			RX_WAIT: begin
				if (!serial_input) begin
					nxt_s.cnt = HALF_CYC - 16'h1;
				end else if (s_ff.cnt == 16'h0) begin
					nxt_s.st = RX_IDLE;
				end else begin
					nxt_s.cnt = s_ff.cnt - 16'h1;
				end
			end
			default: begin
				nxt_s.st = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '{st: RX_IDLE, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lnk.done = s_ff.done;
	assign lnk.data = s_ff.data;
	assign lnk.perr = s_ff.perr;
	assign lnk.ferr = s_ff.ferr;
	assign lnk.brk  = s_ff.brk;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	chk_break_wait_high: assert property (
		s_ff.st == RX_WAIT && !serial_input |=> s_ff.st == RX_WAIT [*2])
		else $error("receiver left break wait without high line");
	chk_frame_fault: assert property (
		s_ff.st == RX_STOP && s_ff.cnt == 16'h0 |=> lnk.done && lnk.ferr == $past(!serial_input))
		else $error("framing fault not taken from stop bit");
	cov_break: cover property (lnk.done && lnk.brk);
endmodule

// *** design/uart_line_status_logic.sv ***
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "uart_line_status_params.svh"
module uart_line_status_logic #(
	parameter int CPB   = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// register port
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output wire logic [7:0] rd_data,
	// serial line
	input  wire logic       serial_input,
	// transmitter shift register
	input  wire logic       tx_take,
	input  wire logic       tx_shift_busy,
	output wire logic [7:0] tx_data,
	output wire logic       tx_parity,
	output wire logic       tx_valid,
	// interrupt requests
	output wire logic       rls_irq,
	output wire logic       tx_holding_empty_irq
);
	import uart_line_status_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || CPB < 2 || CPB > 4095) begin : g_bad
		$error("fifo depth or cycles per bit not supported");
	end

	typedef struct packed {
		logic [7:0]                 lcr;
		logic [3:0]                 ier;
		logic                       fifo_en;
		logic                       dr;
		logic                       oe;
		logic                       pe;
		logic                       fe;
		logic                       bi;
		logic                       tx_holding_empty;
		logic                       tx_all_idle;
		logic                       err_sum;
		logic [7:0]                 rbr;
		logic [7:0]                 thr;
		logic                       thr_full;
		logic [DEPTH-1:0][10:0]     rx_mem;
		logic [AW-1:0]              rx_rp;
		logic [AW-1:0]              rx_wp;
		logic [AW:0]                rx_cnt;
		logic [AW:0]                err_cnt;
		logic [DEPTH-1:0][7:0]      tx_mem;
		logic [AW-1:0]              tx_rp;
		logic [AW-1:0]              tx_wp;
		logic [AW:0]                tx_cnt;
		logic                       two_seen;
		logic [15:0]                dly;
		logic                       tx_holding_empty_pend;
		logic [7:0]                 rd_data;
		logic                       rls_irq;
		logic                       tx_holding_empty_irq;
		logic [7:0]                 tx_data;
		logic                       tx_par;
		logic                       tx_valid;
	} stat_regs_type;

	stat_regs_type s_ff;
	stat_regs_type nxt_s;

	rx_link_if lnk ();

	uart_rx_frame #(
		.CPB (CPB)
	) u_rx (
		.clk_sys      (clk_sys),
		.arst_n       (arst_n),
		.serial_input (serial_input),
		.lnk          (lnk.rx)
	);

	assign lnk.word_len = s_ff.lcr[1:0];
	assign lnk.par_en   = s_ff.lcr[`LC_PAR_EN];
	assign lnk.even     = s_ff.lcr[`LC_EVEN];

	function automatic logic hit(input logic stb, input logic [2:0] a, input logic [2:0] off);
		hit = stb && a == off;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic        rd_rbr, rd_lsr, wr_thr, wr_lsr, wr_fcr;
	logic        rx_pop, rx_push, head_chg, rx_clr, tx_clr, tx_pop, tx_push;
	logic [10:0] head;
	logic        head_ok;

	always_comb begin
		nxt_s = s_ff;
		rd_rbr = hit(rd_stb, addr, `ADDR_DATA);
		rd_lsr = hit(rd_stb, addr, `ADDR_LINE_STAT);
		wr_thr = hit(wr_stb, addr, `ADDR_DATA);
		wr_lsr = hit(wr_stb, addr, `ADDR_LINE_STAT);
		wr_fcr = hit(wr_stb, addr, `ADDR_FIFO_CTRL);
		head = 11'h000;
		head_ok = 1'b0;
		head_chg = 1'b0;
		rx_clr = 1'b0;
		tx_clr = 1'b0;

		// register writes
		if (hit(wr_stb, addr, `ADDR_LINE_CTRL)) begin
			nxt_s.lcr = wr_data;
		end
		if (hit(wr_stb, addr, `ADDR_INT_EN)) begin
			nxt_s.ier = wr_data[3:0];
		end
		if (wr_fcr) begin
			nxt_s.fifo_en = wr_data[`FC_ENABLE];
			rx_clr = !wr_data[`FC_ENABLE] || wr_data[`FC_RX_CLR];
			tx_clr = wr_data[`FC_ENABLE] && wr_data[`FC_TX_CLR];
			if (wr_data[`FC_ENABLE] != s_ff.fifo_en) begin
				nxt_s.tx_holding_empty_pend = 1'b1;
			end
		end

		// clears, then software writes, then hardware sets
		if (rd_lsr) begin
			{nxt_s.oe, nxt_s.pe, nxt_s.fe, nxt_s.bi} = 4'h0;
		end
		if (rd_rbr && !s_ff.fifo_en) begin
			nxt_s.dr = 1'b0;
		end
		if (wr_lsr) begin
			{nxt_s.tx_all_idle, nxt_s.tx_holding_empty, nxt_s.bi, nxt_s.fe, nxt_s.pe, nxt_s.oe, nxt_s.dr} =
				wr_data[6:0];
		end

		// receive path
		rx_pop = s_ff.fifo_en && rd_rbr && s_ff.rx_cnt != '0;
		rx_push = s_ff.fifo_en && lnk.done && s_ff.rx_cnt != FULL;
		if (lnk.done && !s_ff.fifo_en) begin
			nxt_s.rbr = lnk.data;
			nxt_s.dr = 1'b1;
			if (s_ff.dr && !rd_rbr) begin
				nxt_s.oe = 1'b1;
			end
			nxt_s.pe = nxt_s.pe | lnk.perr;
			nxt_s.fe = nxt_s.fe | lnk.ferr;
			nxt_s.bi = nxt_s.bi | lnk.brk;
		end
		if (lnk.done && s_ff.fifo_en && s_ff.rx_cnt == FULL) begin
			nxt_s.oe = 1'b1;
		end
		if (rx_push) begin
			nxt_s.rx_mem[s_ff.rx_wp] = {lnk.brk, lnk.ferr, lnk.perr, lnk.data};
			nxt_s.rx_wp = s_ff.rx_wp + 1'b1;
		end
		if (rx_pop) begin
			nxt_s.rx_rp = s_ff.rx_rp + 1'b1;
		end
		nxt_s.rx_cnt = s_ff.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
		nxt_s.err_cnt = s_ff.err_cnt
			+ (AW + 1)'(rx_push && (lnk.brk || lnk.ferr || lnk.perr))
			- (AW + 1)'(rx_pop && s_ff.rx_mem[s_ff.rx_rp][10:8] != 3'h0);
		if (rx_clr) begin
			nxt_s.rx_rp = '0;
			nxt_s.rx_wp = '0;
			nxt_s.rx_cnt = '0;
			nxt_s.err_cnt = '0;
		end
		// head of the fifo shows its own error bits
		head_chg = rx_pop || (rx_push && s_ff.rx_cnt == '0);
		if (nxt_s.rx_cnt != '0) begin
			head = nxt_s.rx_mem[nxt_s.rx_rp];
			head_ok = 1'b1;
		end
		if (s_ff.fifo_en && head_chg) begin
			{nxt_s.bi, nxt_s.fe, nxt_s.pe} = head_ok ? head[10:8] : 3'h0;
		end
		if (nxt_s.fifo_en) begin
			nxt_s.dr = nxt_s.rx_cnt != '0;
		end
		if (rx_push && (lnk.brk || lnk.ferr || lnk.perr)) begin
			nxt_s.err_sum = 1'b1;
		end else if (rd_lsr) begin
			nxt_s.err_sum = nxt_s.err_cnt != '0;
		end

		// transmit path, character mode
		if (!s_ff.fifo_en) begin
			if (tx_take && s_ff.thr_full) begin
				nxt_s.thr_full = 1'b0;
				nxt_s.tx_holding_empty = 1'b1;
			end
			if (wr_thr) begin
				nxt_s.thr = wr_data;
				nxt_s.thr_full = 1'b1;
				nxt_s.tx_holding_empty = 1'b0;
			end
		end

		// transmit path, fifo mode
		tx_pop = s_ff.fifo_en && tx_take && s_ff.tx_cnt != '0;
		tx_push = s_ff.fifo_en && wr_thr && s_ff.tx_cnt != FULL;
		if (tx_push) begin
			nxt_s.tx_mem[s_ff.tx_wp] = wr_data;
			nxt_s.tx_wp = s_ff.tx_wp + 1'b1;
		end
		if (tx_pop) begin
			nxt_s.tx_rp = s_ff.tx_rp + 1'b1;
		end
		nxt_s.tx_cnt = s_ff.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
		if (tx_clr) begin
			nxt_s.tx_rp = '0;
			nxt_s.tx_wp = '0;
			nxt_s.tx_cnt = '0;
		end
		if (s_ff.dly != 16'h0) begin
			nxt_s.dly = s_ff.dly - 16'h1;
		end
		if (nxt_s.tx_cnt > (AW + 1)'(1)) begin
			nxt_s.two_seen = 1'b1;
		end
		if (nxt_s.tx_cnt != '0) begin
			nxt_s.dly = 16'h0;
		end else if (s_ff.tx_cnt != '0) begin
			nxt_s.two_seen = 1'b0;
			if (!s_ff.two_seen) begin
				nxt_s.dly = 16'(frame_less_stop(s_ff.lcr) * 16'(CPB));
			end
		end
		if (nxt_s.fifo_en) begin
			nxt_s.tx_holding_empty = nxt_s.tx_cnt == '0 && nxt_s.dly == 16'h0;
			nxt_s.tx_all_idle = nxt_s.tx_cnt == '0 && !tx_shift_busy;
		end else if (!wr_lsr) begin
			nxt_s.tx_all_idle = !nxt_s.thr_full && !tx_shift_busy;
		end
		if (nxt_s.tx_holding_empty && !s_ff.tx_holding_empty) begin
			nxt_s.tx_holding_empty_pend = 1'b1;
		end
		if (wr_thr) begin
			nxt_s.tx_holding_empty_pend = 1'b0;
		end

		// outputs
		nxt_s.rls_irq = nxt_s.ier[`IE_RLS] &&
			(nxt_s.oe || nxt_s.pe || nxt_s.fe || nxt_s.bi);
		nxt_s.tx_holding_empty_irq = nxt_s.ier[`IE_TX_HOLDING_EMPTY] && nxt_s.tx_holding_empty_pend;
		nxt_s.tx_valid = nxt_s.fifo_en ? nxt_s.tx_cnt != '0 : nxt_s.thr_full;
		nxt_s.tx_data = nxt_s.fifo_en ? nxt_s.tx_mem[nxt_s.tx_rp] : nxt_s.thr;
		nxt_s.tx_par = parity_gen(nxt_s.tx_data, nxt_s.lcr[1:0], nxt_s.lcr[`LC_EVEN]);
		nxt_s.rd_data = 8'h00;
		if (rd_stb) begin
			case (addr)
				`ADDR_DATA:      nxt_s.rd_data = s_ff.fifo_en ? s_ff.rx_mem[s_ff.rx_rp][7:0] :
					s_ff.rbr;
				`ADDR_INT_EN:    nxt_s.rd_data = {4'h0, s_ff.ier};
				`ADDR_FIFO_CTRL: nxt_s.rd_data = {s_ff.fifo_en, s_ff.fifo_en, 6'h00};
				`ADDR_LINE_CTRL: nxt_s.rd_data = s_ff.lcr;
				`ADDR_LINE_STAT: nxt_s.rd_data = {s_ff.fifo_en && s_ff.err_sum, s_ff.tx_all_idle,
					s_ff.tx_holding_empty, s_ff.bi, s_ff.fe, s_ff.pe, s_ff.oe, s_ff.dr};
				default:         nxt_s.rd_data = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_ff <= '{lcr: `RST_LINE_CTRL, ier: `RST_INT_EN, tx_holding_empty: 1'b1, tx_all_idle: 1'b1,
				default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rd_data   = s_ff.rd_data;
	assign tx_data   = s_ff.tx_data;
	assign tx_parity = s_ff.tx_par;
	assign tx_valid  = s_ff.tx_valid;
	assign rls_irq   = s_ff.rls_irq;
	assign tx_holding_empty_irq  = s_ff.tx_holding_empty_irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	chk_ready_on_char: assert property (
		lnk.done && !s_ff.fifo_en && !wr_fcr |=> s_ff.dr)
		else $error("data ready not set by received character");
	chk_ready_read_clr: assert property (
		!s_ff.fifo_en && rd_rbr && !lnk.done && !wr_fcr |=> !s_ff.dr)
		else $error("data ready not cleared by buffer read");
	chk_ready_fifo_cnt: assert property (
		s_ff.fifo_en |-> s_ff.dr == (s_ff.rx_cnt != '0))
		else $error("data ready does not follow fifo fill");
	chk_overrun_char: assert property (
		!s_ff.fifo_en && lnk.done && s_ff.dr && !rd_rbr && !wr_fcr |=> s_ff.oe)
		else $error("overrun missed in character mode");
	chk_status_read_clr: assert property (
		rd_lsr && !lnk.done && !wr_stb && !head_chg |=> {s_ff.oe, s_ff.pe, s_ff.fe, s_ff.bi} == 4'h0)
		else $error("error flags survive a status read");
	chk_fifo_full_drop: assert property (
		s_ff.fifo_en && s_ff.rx_cnt == FULL && lnk.done && !rx_pop && !wr_stb
		|=> s_ff.oe && s_ff.rx_cnt == FULL && $stable(s_ff.rx_wp))
		else $error("full fifo accepted a character");
	chk_summary_char: assert property (
		rd_stb && addr == `ADDR_LINE_STAT && !s_ff.fifo_en |=> !s_ff.rd_data[`LS_ERR7])
		else $error("bit 7 set in character mode");
	chk_holding_load: assert property (
		wr_thr && !s_ff.fifo_en && !wr_lsr |=> !s_ff.tx_holding_empty && !s_ff.tx_all_idle)
		else $error("holding load did not clear empty flags");
	chk_fifo_write_busy: assert property (
		tx_push && !tx_clr |=> !s_ff.tx_all_idle && !s_ff.tx_holding_empty && s_ff.tx_valid)
		else $error("transmit fifo write did not clear empty flags");
	chk_rls_irq_gate: assert property (
		!s_ff.ier[`IE_RLS] |-> !s_ff.rls_irq)
		else $error("line status interrupt without enable");
	chk_rls_irq_raise: assert property (
		s_ff.ier[`IE_RLS] && (s_ff.oe || s_ff.pe || s_ff.fe || s_ff.bi) |-> s_ff.rls_irq)
		else $error("line status interrupt not raised");
	chk_fifo_toggle_irq: assert property (
		wr_fcr && wr_data[`FC_ENABLE] != s_ff.fifo_en && s_ff.ier[`IE_TX_HOLDING_EMPTY]
		&& !hit(wr_stb, addr, `ADDR_INT_EN) |=> s_ff.tx_holding_empty_irq)
		else $error("fifo toggle gave no transmit interrupt");
	chk_empty_delay: assert property (
		s_ff.fifo_en && tx_pop && s_ff.tx_cnt == (AW + 1)'(1) && !s_ff.two_seen && !tx_push
		&& !wr_fcr |=> !s_ff.tx_holding_empty [*2])
		else $error("transmit empty not delayed");

	cov_fifo_overrun: cover property (s_ff.fifo_en && lnk.done && s_ff.rx_cnt == FULL);
	cov_char_overrun: cover property (!s_ff.fifo_en && lnk.done && s_ff.dr);
	cov_delay_done: cover property (s_ff.dly == 16'h1 ##1 s_ff.tx_holding_empty);
endmodule

// *** dv/serial_term.sv ***
`timescale 1ns/1ps
module serial_term #(
	parameter int CPB = 4
) (
	// clock
	input  wire logic clk_sys,
	// serial line toward the block
	output logic      serial_input,
	// transmitter shift register
	input  wire logic tx_valid,
	output logic      tx_take,
	output logic      tx_shift_busy
);
	logic stall;
	int   busy_cnt;
	initial begin
		serial_input = 1'b1;
		tx_take = 1'b0;
		stall = 1'b1;
		busy_cnt = 0;
	end
	assign tx_shift_busy = busy_cnt != 0;
	// -------------------------
	// shifter takes head when idle
	// -------------------------
	always @(posedge clk_sys) begin
		tx_take <= 1'b0;
		if (busy_cnt > 0)
			busy_cnt <= busy_cnt - 1;
		if (tx_valid && !stall && busy_cnt == 0 && !tx_take) begin
			tx_take <= 1'b1;
			busy_cnt <= 8;
		end
	end
	task automatic bit_out(input logic v);
		serial_input <= v;
		repeat (CPB) @(posedge clk_sys);
	endtask
	// lsb first, optional parity, stop level chosen
	task automatic send(input logic [7:0] d, input logic par_on, input logic pbit,
		input logic stop);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++)
			bit_out(d[i]);
		if (par_on)
			bit_out(pbit);
		bit_out(stop);
		bit_out(1'b1);
	endtask
	task automatic hold_low(input int n);
		serial_input <= 1'b0;
		repeat (n) @(posedge clk_sys);
		serial_input <= 1'b1;
	endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "uart_line_status_params.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
	import uart_line_status_pkg::*;
	logic clk_sys = 1'b0, arst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wr_data = 8'h00, rd_data, tx_data, q;
	logic serial_input, tx_take, tx_shift_busy, tx_parity, tx_valid, rls_irq, tx_holding_empty_irq;
	int bad_count = 0, n_compared = 0;
	initial forever #50 clk_sys = ~clk_sys;
	uart_line_status_logic #(.CPB(4), .DEPTH(2)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
		.serial_input(serial_input), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
		.tx_data(tx_data), .tx_parity(tx_parity), .tx_valid(tx_valid), .rls_irq(rls_irq),
		.tx_holding_empty_irq(tx_holding_empty_irq));
	serial_term #(.CPB(4)) u_term (.clk_sys(clk_sys), .serial_input(serial_input),
		.tx_valid(tx_valid), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy));
	// -------------------------
	// register port
	// -------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		#1 q = rd_data;
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// -------------------------
	// scenarios
	// -------------------------
	task automatic t_reset();
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h60, q)
		`CHK("irqs", 3'h0, {tx_valid, rls_irq, tx_holding_empty_irq})
		$display("done reset");
	endtask
	task automatic t_rx_char();
		@(posedge clk_sys) u_term.send(8'ha5, 1'b0, 1'b0, 1'b1);
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h61, q)
		@(posedge clk_sys) u_term.send(8'h5a, 1'b0, 1'b0, 1'b1);
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h63, q)
		rd(`ADDR_DATA);
		`CHK("data", 8'h5a, q)
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h60, q)
		$display("done rx_char");
	endtask
	task automatic t_errors();
		wr(`ADDR_LINE_CTRL, 8'h1b);
		@(posedge clk_sys) u_term.send(8'h0f, 1'b1, 1'b1, 1'b1);
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h65, q)
		rd(`ADDR_DATA);
		@(posedge clk_sys) u_term.send(8'h55, 1'b1, 1'b0, 1'b0);
		rd(`ADDR_LINE_STAT);
		`CHK("fe", 8'h08, q & 8'h08)
		rd(`ADDR_DATA);
		wr(`ADDR_INT_EN, 8'h04);
		@(posedge clk_sys) u_term.hold_low(88);
		repeat (8) @(posedge clk_sys);
		`CHK("rls_irq", 1'b1, rls_irq)
		rd(`ADDR_LINE_STAT);
		`CHK("bi", 8'h10, q & 8'h10)
		rd(`ADDR_DATA);
		@(posedge clk_sys) u_term.send(8'h3c, 1'b1, 1'b0, 1'b1);
		rd(`ADDR_DATA);
		`CHK("data", 8'h3c, q)
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h60, q)
		$display("done errors");
	endtask
	task automatic t_sw_write();
		wr(`ADDR_LINE_STAT, 8'hfe);
		repeat (2) @(posedge clk_sys);
		`CHK("rls_irq", 1'b1, rls_irq)
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h7e, q)
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h60, q)
		wr(`ADDR_INT_EN, 8'h00);
		wr(`ADDR_LINE_STAT, 8'h62);
		repeat (2) @(posedge clk_sys);
		`CHK("rls_irq", 1'b0, rls_irq)
		rd(`ADDR_LINE_STAT);
		$display("done sw_write");
	endtask
	task automatic t_tx();
		int n;
		wr(`ADDR_INT_EN, 8'h02);
		wr(`ADDR_DATA, 8'h3c);
		repeat (2) @(posedge clk_sys);
		`CHK("tx head", 10'h23c, {tx_valid, tx_parity, tx_data})
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h00, q)
		u_term.stall <= 1'b0;
		for (n = 0; n < 20 && tx_valid !== 1'b0; n++) begin
			@(posedge clk_sys);
			#1;
		end
		if (n == 20) begin
			bad_count++;
			summarize();
		end
		@(posedge clk_sys);
		`CHK("tx_holding_empty_irq", 1'b1, tx_holding_empty_irq)
		rd(`ADDR_LINE_STAT);
		`CHK("tx_holding_empty", 8'h20, q & 8'h20)
		repeat (12) @(posedge clk_sys);
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h60, q)
		$display("done tx");
	endtask
	task automatic t_fifo();
		wr(`ADDR_FIFO_CTRL, 8'h07);
		@(posedge clk_sys) u_term.send(8'h11, 1'b1, 1'b1, 1'b1);
		@(posedge clk_sys) u_term.send(8'h22, 1'b1, 1'b0, 1'b1);
		@(posedge clk_sys) u_term.send(8'h33, 1'b1, 1'b0, 1'b1);
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'he7, q)
		rd(`ADDR_DATA);
		`CHK("data", 8'h11, q)
		rd(`ADDR_LINE_STAT);
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h61, q)
		rd(`ADDR_DATA);
		`CHK("data", 8'h22, q)
		rd(`ADDR_LINE_STAT);
		`CHK("status", 8'h60, q)
		wr(`ADDR_DATA, 8'h44);
		rd(`ADDR_LINE_STAT);
		`CHK("tx empties", 8'h00, q & 8'h60)
		`CHK("tx_holding_empty_irq", 1'b0, tx_holding_empty_irq)
		repeat (20) @(posedge clk_sys);
		rd(`ADDR_LINE_STAT);
		`CHK("tx empties", 8'h40, q & 8'h60)
		repeat (30) @(posedge clk_sys);
		rd(`ADDR_LINE_STAT);
		`CHK("tx empties", 8'h60, q & 8'h60)
		`CHK("tx_holding_empty_irq", 1'b1, tx_holding_empty_irq)
		$display("done fifo");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_rx_char();
		t_errors();
		t_sw_write();
		t_tx();
		t_fifo();
		summarize();
	end
endmodule
